// ===== pkg/bss_consts.vh
// constants for the binary schedule select block
// assumes inclusion by bare name from design files
`ifndef BSS_CONSTS_VH
`define BSS_CONSTS_VH
// register byte offsets
`define BSS_ADDR_CTRL      8'h00
`define BSS_ADDR_STATUS    8'h04
`define BSS_ADDR_STEP0     8'h08
`define BSS_ADDR_STEP4     8'h18
`define BSS_ADDR_PANEL     8'h1C
// ctrl field layout
`define BSS_CTRL_SEL_LO    0
`define BSS_CTRL_SEL_HI    1
`define BSS_CTRL_SEAM_LO   8
`define BSS_CTRL_SEAM_HI   9
`define BSS_CTRL_STEPPER   16
`define BSS_CTRL_RESET     32'h0000_0000
// select mode codes
`define BSS_SEL_PANEL      2'h0
`define BSS_SEL_TWO        2'h1
`define BSS_SEL_BINARY     2'h3
`define BSS_SEAM_ON        2'h1
// schedules
`define BSS_SCHED_MAX      6'h31
`define BSS_SCHED_00       6'h00
`define BSS_SCHED_10       6'h0A
`define BSS_SCHED_20       6'h14
`define BSS_SCHED_30       6'h1E
`define BSS_SCHED_40       6'h28
// debounce time
`define BSS_DEB_US         1000
`define BSS_CLK_MHZ        100
`define BSS_DEB_CYC        (`BSS_DEB_US * `BSS_CLK_MHZ)
`define BSS_DEB_W          17
// axi responses
`define BSS_RESP_OKAY      2'h0
`define BSS_RESP_SLVERR    2'h2
`endif

// ===== design/bss_debounce.v
// debounce of one synchronised contact input
// assumes the input is already two-flop synchronised
`timescale 1ns/1ns
`include "bss_consts.vh"
module bss_debounce #(
    parameter [`BSS_DEB_W-1:0] DEB_CYC = `BSS_DEB_CYC
) (
    input  wire aclk,
    input  wire aresetn,
    input  wire in_sync,
    output reg  out_q
);
    reg [`BSS_DEB_W-1:0] cnt_q;

    // output changes only after the input held steady for DEB_CYC cycles
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= {`BSS_DEB_W{1'b0}};
            out_q <= 1'b0;
        end else if (in_sync == out_q) begin
            cnt_q <= {`BSS_DEB_W{1'b0}};
        end else if (cnt_q >= DEB_CYC - 1'b1) begin
            cnt_q <= {`BSS_DEB_W{1'b0}};
            out_q <= in_sync;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule // bss_debounce

// ===== design/bss_top.v
// binary schedule select: decodes six contact selects and three
// initiation inputs into a schedule start, with an axi4-lite slave.
// assumes contacts arrive active high (closed = 1), asynchronous.
`timescale 1ns/1ns
`include "bss_consts.vh"
module bss_top #(
    parameter [`BSS_DEB_W-1:0] DEB_CYC = `BSS_DEB_CYC
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [5:0]  select_in,
    input  wire        main_initiate_input,
    input  wire        fixed_ten_initiate_input,
    input  wire        fixed_twenty_initiate_input,
    input  wire        weld_active,
    input  wire        step_advance,
    output reg         start_q,
    output reg  [5:0]  schedule_q,
    output reg  [2:0]  stepper_q,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);
    localparam NIN = 9;

    // clamp and weighting of the six selects
    function [5:0] bin_sched;
        input [5:0] sel;
        begin
            if (sel > `BSS_SCHED_MAX)
                bin_sched = `BSS_SCHED_MAX;
            else
                bin_sched = sel;
        end
    endfunction

    // one-hot stepper decode; several closed picks the lowest weight
    function [2:0] step_dec;
        input [3:0] sel;
        begin
            if (sel[0])
                step_dec = 3'h1;
            else if (sel[1])
                step_dec = 3'h2;
            else if (sel[2])
                step_dec = 3'h3;
            else if (sel[3])
                step_dec = 3'h4;
            else
                step_dec = 3'h0;
        end
    endfunction

    wire [NIN-1:0] raw_in = {fixed_twenty_initiate_input,
                             fixed_ten_initiate_input,
                             main_initiate_input, select_in};
    reg  [NIN-1:0] sync1_q;
    reg  [NIN-1:0] sync2_q;
    wire [NIN-1:0] deb;

    always @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= {NIN{1'b0}};
            sync2_q <= {NIN{1'b0}};
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi = gi + 1) begin : g_deb
            bss_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
                .aclk    (aclk),
                .aresetn (aresetn),
                .in_sync (sync2_q[gi]),
                .out_q   (deb[gi])
            );
        end
    endgenerate

    wire [5:0] sel     = deb[5:0];
    wire       ini_m   = deb[6];
    wire       ini_10  = deb[7];
    wire       ini_20  = deb[8];
    reg  [2:0] ini_prev_q;
    wire       rise_m  = ini_m  & ~ini_prev_q[0];
    wire       rise_10 = ini_10 & ~ini_prev_q[1];
    wire       rise_20 = ini_20 & ~ini_prev_q[2];

    // control registers
    reg  [31:0] ctrl_q;
    reg  [5:0]  panel_q;
    reg  [5:0]  step_pos_q [0:4];
    wire [1:0]  sel_mode = ctrl_q[`BSS_CTRL_SEL_HI:`BSS_CTRL_SEL_LO];
    wire [1:0]  seam     = ctrl_q[`BSS_CTRL_SEAM_HI:`BSS_CTRL_SEAM_LO];
    wire        stepper  = ctrl_q[`BSS_CTRL_STEPPER];
    wire        seam_on  = (seam == `BSS_SEAM_ON);

    // stepper positions: start at A=00 .. E=40, advance per weld
    wire [5:0] step_base [0:4];
    assign step_base[0] = `BSS_SCHED_00;
    assign step_base[1] = `BSS_SCHED_10;
    assign step_base[2] = `BSS_SCHED_20;
    assign step_base[3] = `BSS_SCHED_30;
    assign step_base[4] = `BSS_SCHED_40;

    // requested schedule for the main initiation input
    reg [5:0] req_sched;
    reg [2:0] req_step;
    always @* begin
        req_step = step_dec(sel[3:0]);
        case (sel_mode)
            `BSS_SEL_PANEL:  req_sched = panel_q;
            `BSS_SEL_TWO: begin
                case (sel[1:0])
                    2'h1:    req_sched = `BSS_SCHED_10;
                    2'h2:    req_sched = `BSS_SCHED_20;
                    2'h3:    req_sched = `BSS_SCHED_30;
                    default: req_sched = `BSS_SCHED_00;
                endcase
            end
            // per-stepper position
            // stepper schedule is its base plus its own progress
            `BSS_SEL_BINARY: req_sched = stepper ?
                bin_sched(step_base[req_step] + step_pos_q[req_step]) :
                bin_sched(sel);
            default:         req_sched = panel_q;
        endcase
    end

    wire in_seam_weld = seam_on & weld_active;

    // start pulse and schedule latch
    always @(posedge aclk) begin
        if (!aresetn) begin
            ini_prev_q <= 3'h0;
            start_q    <= 1'b0;
            schedule_q <= `BSS_SCHED_00;
            stepper_q  <= 3'h0;
        end else begin
            ini_prev_q <= {ini_20, ini_10, ini_m};
            start_q    <= 1'b0;
            if (rise_m) begin
                start_q    <= 1'b1;
                schedule_q <= req_sched;
                stepper_q  <= req_step;
            end else if (rise_10) begin
                start_q    <= 1'b1;
                schedule_q <= `BSS_SCHED_10;
            end else if (rise_20) begin
                start_q    <= 1'b1;
                schedule_q <= `BSS_SCHED_20;
            end else if (in_seam_weld) begin
                schedule_q <= req_sched;
            end
        end
    end

    // axi4-lite write path
    reg        aw_hold_q;
    reg        w_hold_q;
    reg [7:0]  awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0]  wstrb_q;
    wire       do_wr = aw_hold_q & w_hold_q & ~s_axi_bvalid;
    wire [2:0] wr_idx = awaddr_q[4:2] - 3'h2;
    wire       wr_step = (awaddr_q >= `BSS_ADDR_STEP0) &&
                         (awaddr_q <= `BSS_ADDR_STEP4);
    wire [31:0] ctrl_new = {wstrb_q[3] ? wdata_q[31:24] : ctrl_q[31:24],
                            wstrb_q[2] ? wdata_q[23:16] : ctrl_q[23:16],
                            wstrb_q[1] ? wdata_q[15:8]  : ctrl_q[15:8],
                            wstrb_q[0] ? wdata_q[7:0]   : ctrl_q[7:0]};
    integer k;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q     <= 1'b0;
            w_hold_q      <= 1'b0;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `BSS_RESP_OKAY;
            ctrl_q        <= `BSS_CTRL_RESET;
            panel_q       <= `BSS_SCHED_00;
            for (k = 0; k < 5; k = k + 1)
                step_pos_q[k] <= 6'h00;
        end else begin
            s_axi_awready <= ~aw_hold_q & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_hold_q & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (s_axi_bvalid & s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (start_q && stepper && step_advance == 1'b0) begin
                step_pos_q[stepper_q] <= step_pos_q[stepper_q];
            end
            // advance the stepper that just ran; others keep their place
            if (step_advance && stepper)
                step_pos_q[stepper_q] <= step_pos_q[stepper_q] + 6'h01;
            if (do_wr) begin
                aw_hold_q    <= 1'b0;
                w_hold_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `BSS_RESP_OKAY;
                if (awaddr_q == `BSS_ADDR_CTRL)
                    ctrl_q <= ctrl_new;
                else if (awaddr_q == `BSS_ADDR_PANEL)
                    panel_q <= bin_sched(wdata_q[5:0]);
                else if (wr_step)
                    step_pos_q[wr_idx] <= bin_sched(wdata_q[5:0]);
                else
                    s_axi_bresp <= `BSS_RESP_SLVERR;
            end
        end
    end

    // axi4-lite read path
    wire [2:0] rd_idx = s_axi_araddr[4:2] - 3'h2;
    reg [31:0] rd_val;
    reg        rd_ok;
    always @* begin
        rd_ok  = 1'b1;
        rd_val = 32'h0000_0000;
        if (s_axi_araddr == `BSS_ADDR_CTRL)
            rd_val = ctrl_q;
        else if (s_axi_araddr == `BSS_ADDR_STATUS)
            rd_val = {13'h0000, ini_20, ini_10, ini_m, sel,
                      stepper_q, start_q, schedule_q};
        else if (s_axi_araddr == `BSS_ADDR_PANEL)
            rd_val = {26'h000_0000, panel_q};
        else if (s_axi_araddr >= `BSS_ADDR_STEP0 &&
                 s_axi_araddr <= `BSS_ADDR_STEP4)
            rd_val = {26'h000_0000, step_pos_q[rd_idx] + step_base[rd_idx]};
        else
            rd_ok = 1'b0;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `BSS_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_val;
                s_axi_rresp  <= rd_ok ? `BSS_RESP_OKAY : `BSS_RESP_SLVERR;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // bss_top

// ===== verif/bss_plc_model.sv
// plc model: drives the six selects and three initiation contacts
// assumes the bench hands it the wanted combination on a clock edge
`timescale 1ns/1ns
module bss_plc_model (
    input  wire        aclk,
    input  wire [5:0]  sel_req,
    input  wire [2:0]  pin_req,
    output logic [5:0] select_in,
    output logic [2:0] pins
);
    initial select_in = 6'h00;
    initial pins = 3'h0;
    always @(posedge aclk) begin
        select_in <= sel_req;
        pins <= pin_req;
    end
endmodule // bss_plc_model

// ===== verif/bss_monitor.sv
// checker on the ports of the schedule select top
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ns
module bss_monitor (
    input wire       aclk,
    input wire       aresetn,
    input wire       main_initiate_input,
    input wire       fixed_ten_initiate_input,
    input wire       fixed_twenty_initiate_input,
    input wire       weld_active,
    input wire       start_q,
    input wire [5:0] schedule_q,
    input wire [2:0] stepper_q,
    input wire       s_axi_awvalid,
    input wire       s_axi_awready,
    input wire       s_axi_bvalid,
    input wire       s_axi_bready,
    input wire       s_axi_arvalid,
    input wire       s_axi_arready,
    input wire       s_axi_rvalid,
    input wire       s_axi_rready
);
    wire any_pin = main_initiate_input | fixed_ten_initiate_input
        | fixed_twenty_initiate_input;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sched_clamp_a: assert property (schedule_q <= 6'h31)
        else $error("schedule above 49");
    stepper_range_a: assert property (stepper_q <= 3'h4)
        else $error("stepper index above E");
    sched_hold_a: assert property ($changed(schedule_q) |->
        start_q || weld_active || $past(weld_active))
        else $error("schedule moved without start or seam weld");
    // contacts need sync and debounce, so a start lags its pin
    start_cause_a: assert property (start_q |-> $past(any_pin, 3))
        else $error("start without an initiation contact");
    aw_taken_a: assert property (s_axi_awvalid && !s_axi_awready
        |-> ##[1:4] s_axi_awready) else $error("write address not taken");
    ar_taken_a: assert property (s_axi_arvalid && !s_axi_arready
        && !s_axi_rvalid |-> ##[1:4] s_axi_arready)
        else $error("read address not taken");
    bresp_done_a: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid) else $error("bvalid after handshake");
    rresp_done_a: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid) else $error("rvalid after handshake");
    cover property (start_q && fixed_ten_initiate_input);
    cover property (weld_active && $changed(schedule_q));
    cover property (start_q && stepper_q == 3'h4);
endmodule // bss_monitor
bind bss_top bss_monitor i_bss_monitor (.aclk, .aresetn,
    .main_initiate_input, .fixed_ten_initiate_input,
    .fixed_twenty_initiate_input, .weld_active, .start_q, .schedule_q,
    .stepper_q, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready);

// ===== verif/bss_top_bench.sv
// self-checking bench for the schedule select top with a plc model
// assumes debounce shortened to 4 cycles, so 12 cycles settle a contact
`timescale 1ns/1ns
`include "bss_consts.vh"
module bss_top_bench;
    logic        aclk = 0;
    logic        aresetn = 0;
    logic [5:0]  sel_req = 0;
    logic [2:0]  pin_req = 0;
    logic        weld_active = 0;
    logic        step_advance = 0;
    logic [7:0]  awaddr = 0;
    logic [7:0]  araddr = 0;
    logic [31:0] wdata = 0;
    logic        awvalid = 0;
    logic        wvalid = 0;
    logic        arvalid = 0;
    logic [31:0] rd;
    logic [1:0]  rs;
    wire  [5:0]  select_in;
    wire  [2:0]  pins;
    wire         start_q, awready, wready, bvalid, arready, rvalid;
    wire  [5:0]  schedule_q;
    wire  [2:0]  stepper_q;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    int          error_cnt = 0;
    int          checked = 0;
    int          vals[$] = '{0, 1, 31, 48, 49, 50, 63};
    int          k;
    always #5 aclk = ~aclk;
    bss_top #(.DEB_CYC(17'h0_0004)) i_bss_top (.aclk(aclk),
        .aresetn(aresetn), .select_in(select_in),
        .main_initiate_input(pins[0]), .fixed_ten_initiate_input(pins[1]),
        .fixed_twenty_initiate_input(pins[2]), .weld_active(weld_active),
        .step_advance(step_advance), .start_q(start_q),
        .schedule_q(schedule_q), .stepper_q(stepper_q),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));
    bss_plc_model i_bss_plc_model (.aclk(aclk), .sel_req(sel_req),
        .pin_req(pin_req), .select_in(select_in), .pins(pins));
    task final_report;
        if (error_cnt == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task lim(input int n);
        if (n >= 40) begin
            error_cnt++;
            final_report();
        end
    endtask
    // bready and rready stay high, so the answer edge ends each access
    task axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        n = 0;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 0;
            if (wready === 1'b1) wvalid <= 0;
            n++;
        end while (bvalid !== 1'b1 && n < 40);
        rs = bresp;
        lim(n);
    endtask
    task axi_rd(input logic [7:0] a);
        int n;
        araddr <= a;
        arvalid <= 1;
        n = 0;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 0;
            n++;
        end while (rvalid !== 1'b1 && n < 40);
        rd = rdata;
        rs = rresp;
        lim(n);
    endtask
    task press(input logic [5:0] s, input logic [2:0] p, input int es, est);
        int n;
        sel_req <= s;
        repeat (12) @(posedge aclk);
        pin_req <= p;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (start_q !== 1'b1 && n < 40);
        lim(n);
        chk("schedule", schedule_q, es[31:0]);
        if (est < 5) chk("stepper", stepper_q, est[31:0]);
        pin_req <= 0;
        repeat (12) @(posedge aclk);
    endtask
    function int exp_bin(input int v);
        return v > 49 ? 49 : v;
    endfunction
    initial begin
        k = $urandom(32'he4ba);
        repeat (4) vals.push_back($urandom % 64);
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        axi_rd(`BSS_ADDR_CTRL);
        chk("ctrl reset", rd, 32'h0000_0000);
        axi_rd(8'h20);
        chk("rresp unmapped", rs, `BSS_RESP_SLVERR);
        axi_wr(8'h24, 32'h0000_0001);
        chk("bresp unmapped", rs, `BSS_RESP_SLVERR);
        axi_wr(`BSS_ADDR_PANEL, 32'h0000_003C);
        axi_rd(`BSS_ADDR_PANEL);
        chk("panel clamp", rd, 32'h0000_0031);
        axi_wr(`BSS_ADDR_PANEL, 32'h0000_0007);
        press(6'h21, 3'h1, 7, 7);
        axi_wr(`BSS_ADDR_CTRL, 32'h0000_0001);
        for (k = 0; k < 4; k++) press(k, 3'h1, k * 10, 7);
        axi_wr(`BSS_ADDR_CTRL, 32'h0000_0003);
        foreach (vals[i]) press(vals[i], 3'h1, exp_bin(vals[i]), 7);
        press(6'h05, 3'h2, 10, 7);
        press(6'h05, 3'h4, 20, 7);
        axi_wr(`BSS_ADDR_CTRL, 32'h0001_0003);
        for (k = 0; k < 5; k++)
            press(k == 0 ? 0 : 1 << (k - 1), 3'h1, k * 10, k);
        step_advance <= 1;
        @(posedge aclk);
        step_advance <= 0;
        press(6'h02, 3'h1, 20, 2);
        press(6'h08, 3'h1, 41, 4);
        axi_wr(`BSS_ADDR_CTRL, 32'h0000_0103);
        press(6'h00, 3'h1, 0, 7);
        weld_active <= 1;
        sel_req <= 6'h01;
        repeat (12) @(posedge aclk);
        chk("seam follow", schedule_q, 32'h0000_0001);
        weld_active <= 0;
        axi_rd(`BSS_ADDR_STATUS);
        chk("status", rd, 32'h0000_0401);
        final_report();
    end
endmodule // bss_top_bench
